// ===== hdl/emp_pkg.sv
package emp_pkg;
  localparam logic [31:0] OFF_PORT_CFG  = 32'h0000_0000;
  localparam logic [31:0] OFF_BUS_CTRL  = 32'h0000_0004;
  localparam logic [31:0] OFF_UP_IO     = 32'h0000_0008;
  localparam logic [31:0] OFF_LO_IO     = 32'h0000_000c;
  localparam logic [31:0] OFF_STACK     = 32'h0000_0010;
  localparam logic [31:0] OFF_XFER      = 32'h0000_0014;
  localparam logic [31:0] OFF_STATUS    = 32'h0000_0018;
  localparam logic [31:0] OFF_RDATA     = 32'h0000_001c;
  // Port config field positions
  localparam int CFG_UP_LO_MODE = 0;  // 2 bits: 0 in,1 out,2 addr
  localparam int CFG_UP_HI_MODE = 2;  // 2 bits
  localparam int CFG_LO_MODE    = 4;  // 2 bits: 0 in,1 out,2 addr/data
  localparam int CFG_UP_HS      = 6;
  localparam int CFG_LO_HS      = 7;
  localparam int CFG_OPEN_DRAIN = 8;
  localparam int CFG_LOW_EMI    = 9;
  localparam int CFG_EXT_TIMING = 10;
  localparam int CFG_FLOAT      = 11;
  localparam logic [1:0] MODE_IN   = 2'h0;
  localparam logic [1:0] MODE_OUT  = 2'h1;
  localparam logic [1:0] MODE_ADDR = 2'h2;
  localparam logic [11:0] CFG_RST_EXT = 12'h42a;
  localparam logic [11:0] CFG_RST_INT = 12'h000;
  localparam int XF_WRITE = 16;
  localparam int XF_STOP_REC = 17;
  // Machine-cycle phase lengths in clocks; extended timing adds a wait
  localparam logic [2:0] T_ADDR = 3'h1;
  localparam logic [2:0] T_HOLD = 3'h1;
  localparam logic [2:0] T_DATA = 3'h2;
  localparam logic [2:0] T_EXT  = 3'h2;
  localparam logic [15:0] SP_RST = 16'h0000;
  typedef enum logic [2:0] {
    EMP_IDLE, EMP_ADDR, EMP_HOLD, EMP_DATA, EMP_END
  } emp_state_e;
endpackage : emp_pkg

// ===== hdl/emp_ahb_slave.sv
`timescale 1ns/1ps
`default_nettype none
module emp_ahb_slave (
  input  wire  logic        I_REF_CLK,
  input  wire  logic        I_RST,
  input  wire  logic        i_hsel,
  input  wire  logic [31:0] i_haddr,
  input  wire  logic [1:0]  i_htrans,
  input  wire  logic        i_hwrite,
  input  wire  logic        i_hready,
  output logic              o_wr,
  output logic              o_rd,
  output logic [31:0]       o_addr
);
  import emp_pkg::*;
  logic        ph_wr;
  logic        ph_rd;
  logic [31:0] ph_addr;
  logic        next_ph_wr;
  logic        next_ph_rd;
  logic [31:0] next_ph_addr;
  always_comb begin
    next_ph_wr   = 1'b0;
    next_ph_rd   = 1'b0;
    next_ph_addr = ph_addr;
    if (i_hready && i_hsel && i_htrans[1]) begin
      next_ph_wr   = i_hwrite;
      next_ph_rd   = !i_hwrite;
      next_ph_addr = i_haddr;
    end
  end
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      ph_wr   <= 1'b0;
      ph_rd   <= 1'b0;
      ph_addr <= 32'h0000_0000;
    end else begin
      ph_wr   <= next_ph_wr;
      ph_rd   <= next_ph_rd;
      ph_addr <= next_ph_addr;
    end
  end
  assign o_wr   = ph_wr;
  assign o_rd   = ph_rd;
  assign o_addr = ph_addr;
endmodule // emp_ahb_slave
`default_nettype wire

// ===== hdl/emp_pad_drv.sv
`timescale 1ns/1ps
`default_nettype none
module emp_pad_drv (
  input  wire  logic [7:0] i_val,
  input  wire  logic [7:0] i_drive,
  input  wire  logic       i_open_drain,
  output logic [7:0]       o_out,
  output logic [7:0]       o_oe
);
  // Open drain only ever pulls low; the pin floats for a one
  always_comb begin
    o_out = i_val;
    o_oe  = i_drive;
    if (i_open_drain) begin
      o_out = 8'h00;
      o_oe  = i_drive & ~i_val;
    end
  end
endmodule // emp_pad_drv
`default_nettype wire

// ===== hdl/emp_ext_mem_port.sv
`timescale 1ns/1ps
`default_nettype none
module emp_ext_mem_port (
  input  wire  logic        I_REF_CLK,
  input  wire  logic        I_RST,
  input  wire  logic        I_HSEL,
  input  wire  logic [31:0] I_HADDR,
  input  wire  logic [1:0]  I_HTRANS,
  input  wire  logic        I_HWRITE,
  input  wire  logic [2:0]  I_HSIZE,
  input  wire  logic [31:0] I_HWDATA,
  input  wire  logic        I_HREADY,
  output logic [31:0]       O_HRDATA,
  output logic              O_HREADYOUT,
  output logic              O_HRESP,
  input  wire  logic        I_EXT_ONLY_SELECT_N,
  output logic              O_ADDR_LATCH_STROBE_N,
  output logic              O_ADDR_LATCH_STROBE_OE,
  output logic              O_TRANSFER_STROBE_N,
  output logic              O_TRANSFER_STROBE_OE,
  output logic              O_READ_WRITE,
  output logic              O_READ_WRITE_OE,
  input  wire  logic [7:0]  I_UPPER_ADDR_PORT_PINS,
  output logic [7:0]        O_UPPER_ADDR_PORT_PINS,
  output logic [7:0]        O_UPPER_ADDR_PORT_PINS_OE,
  input  wire  logic [7:0]  I_LOW_ADDR_DATA_PORT_PINS,
  output logic [7:0]        O_LOW_ADDR_DATA_PORT_PINS,
  output logic [7:0]        O_LOW_ADDR_DATA_PORT_PINS_OE,
  input  wire  logic        I_PORT3_LINE2,
  input  wire  logic        I_PORT3_LINE3,
  output logic              O_PORT3_LINE4,
  output logic              O_PORT3_LINE5,
  output logic              O_LOW_EMI
);
  import emp_pkg::*;
  logic        wr;
  logic [31:0] addr;
  logic [11:0] cfg;
  logic [11:0] next_cfg;
  logic        rst_seen;
  logic        next_rst_seen;
  logic [7:0]  up_io;
  logic [7:0]  next_up_io;
  logic [7:0]  lo_io;
  logic [7:0]  next_lo_io;
  logic [15:0] sp;
  logic [15:0] next_sp;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  emp_state_e  state;
  emp_state_e  next_state;
  logic [2:0]  cnt;
  logic [2:0]  next_cnt;
  logic [15:0] xaddr;
  logic [15:0] next_xaddr;
  logic [7:0]  xdata;
  logic [7:0]  next_xdata;
  logic        xwrite;
  logic        next_xwrite;
  logic [7:0]  mem_rd;
  logic [7:0]  next_mem_rd;
  logic        busy;
  logic [7:0]  up_val;
  logic [7:0]  up_drv;
  logic [7:0]  lo_val;
  logic [7:0]  lo_drv;
  logic        cfg_err;

  emp_ahb_slave u_slave (
    .I_REF_CLK (I_REF_CLK),
    .I_RST     (I_RST),
    .i_hsel    (I_HSEL),
    .i_haddr   (I_HADDR),
    .i_htrans  (I_HTRANS),
    .i_hwrite  (I_HWRITE),
    .i_hready  (I_HREADY),
    .o_wr      (wr),
    .o_rd      (),
    .o_addr    (addr)
  );

  function automatic logic [2:0] data_len(input logic ext);
    data_len = ext ? 3'(T_DATA + T_EXT) : T_DATA;
  endfunction

  assign busy = (state != EMP_IDLE);
  // Bus write is taken in the data phase; no wait states
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP     = 1'b0;
  assign O_HRDATA    = rdata;

  // Reset-time mode capture, done one clock after release
  always_comb begin
    next_rst_seen = 1'b1;
    next_cfg      = cfg;
    next_up_io    = up_io;
    next_lo_io    = lo_io;
    next_sp       = sp;
    if (!rst_seen) begin
      next_cfg = I_EXT_ONLY_SELECT_N ? CFG_RST_INT : CFG_RST_EXT;
    end else if (wr) begin
      unique case (addr)
        OFF_PORT_CFG: next_cfg   = I_HWDATA[11:0];
        OFF_UP_IO:    next_up_io = I_HWDATA[7:0];
        OFF_LO_IO:    next_lo_io = I_HWDATA[7:0];
        OFF_STACK:    next_sp    = I_HWDATA[15:0];
        OFF_XFER: begin
          if (I_HWDATA[XF_STOP_REC]) begin
            next_sp = SP_RST;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      rst_seen <= 1'b0;
      cfg      <= CFG_RST_INT;
      up_io    <= 8'h00;
      lo_io    <= 8'h00;
      sp       <= SP_RST;
    end else begin
      rst_seen <= next_rst_seen;
      cfg      <= next_cfg;
      up_io    <= next_up_io;
      lo_io    <= next_lo_io;
      sp       <= next_sp;
    end
  end

  // External transfer sequencer: one machine cycle per request
  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_xaddr  = xaddr;
    next_xdata  = xdata;
    next_xwrite = xwrite;
    next_mem_rd = mem_rd;
    unique case (state)
      EMP_IDLE: begin
        if (wr && addr == OFF_XFER && rst_seen) begin
          next_xaddr  = I_HWDATA[15:0];
          next_xdata  = I_HWDATA[31:24];
          next_xwrite = I_HWDATA[XF_WRITE];
          next_cnt    = T_ADDR;
          next_state  = EMP_ADDR;
        end
      end
      EMP_ADDR: begin
        next_cnt = 3'(cnt - 3'h1);
        if (cnt == 3'h1) begin
          next_cnt   = T_HOLD;
          next_state = EMP_HOLD;
        end
      end
      EMP_HOLD: begin
        next_cnt = 3'(cnt - 3'h1);
        if (cnt == 3'h1) begin
          next_cnt   = data_len(cfg[CFG_EXT_TIMING]);
          next_state = EMP_DATA;
        end
      end
      EMP_DATA: begin
        next_cnt = 3'(cnt - 3'h1);
        if (cnt == 3'h1) begin
          if (!xwrite) begin
            next_mem_rd = I_LOW_ADDR_DATA_PORT_PINS;
          end
          next_state = EMP_END;
        end
      end
      EMP_END: begin
        next_state = EMP_IDLE;
      end
      default: next_state = EMP_IDLE;
    endcase
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      state  <= EMP_IDLE;
      cnt    <= 3'h0;
      xaddr  <= 16'h0000;
      xdata  <= 8'h00;
      xwrite <= 1'b0;
      mem_rd <= 8'h00;
    end else begin
      state  <= next_state;
      cnt    <= next_cnt;
      xaddr  <= next_xaddr;
      xdata  <= next_xdata;
      xwrite <= next_xwrite;
      mem_rd <= next_mem_rd;
    end
  end

  // Handshake direction must agree across nibbles
  assign cfg_err = cfg[CFG_UP_HS] &&
                   (cfg[CFG_UP_HI_MODE+:2] != cfg[CFG_UP_LO_MODE+:2]);

  // Read data is fetched in the address phase so it stands through the
  // whole data phase; the bus never has to wait for it
  always_comb begin
    next_rdata = rdata;
    if (I_HREADY && I_HSEL && I_HTRANS[1] && !I_HWRITE) begin
      unique case (I_HADDR)
        OFF_PORT_CFG: next_rdata = {20'h0, cfg};
        OFF_UP_IO:    next_rdata = {24'h0, I_UPPER_ADDR_PORT_PINS};
        OFF_LO_IO:    next_rdata = {24'h0, I_LOW_ADDR_DATA_PORT_PINS};
        OFF_STACK:    next_rdata = {16'h0, sp};
        OFF_STATUS:   next_rdata = {26'h0, I_PORT3_LINE3, I_PORT3_LINE2,
                                    cfg_err, !I_EXT_ONLY_SELECT_N,
                                    xwrite, busy};
        OFF_RDATA:    next_rdata = {24'h0, mem_rd};
        default:      next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Pin data: upper address in every phase; low port address in addr/hold phases, write data in data phase
  always_comb begin
    up_val = up_io;
    up_drv = 8'h00;
    if (cfg[CFG_UP_LO_MODE+:2] == MODE_ADDR) begin
      up_val[3:0] = xaddr[11:8];
      up_drv[3:0] = 4'hf;
    end else if (cfg[CFG_UP_LO_MODE+:2] == MODE_OUT) begin
      up_drv[3:0] = 4'hf;
    end
    if (cfg[CFG_UP_HI_MODE+:2] == MODE_ADDR) begin
      up_val[7:4] = xaddr[15:12];
      up_drv[7:4] = 4'hf;
    end else if (cfg[CFG_UP_HI_MODE+:2] == MODE_OUT) begin
      up_drv[7:4] = 4'hf;
    end
    lo_val = lo_io;
    lo_drv = (cfg[CFG_LO_MODE+:2] == MODE_OUT) ? 8'hff : 8'h00;
    if (cfg[CFG_LO_MODE+:2] == MODE_ADDR) begin
      lo_drv = 8'h00;
      if (state == EMP_ADDR || state == EMP_HOLD) begin
        lo_val = xaddr[7:0];
        lo_drv = 8'hff;
      end else if (state == EMP_DATA && xwrite) begin
        lo_val = xdata;
        lo_drv = 8'hff;
      end
    end
    if (cfg[CFG_FLOAT]) begin
      up_drv = 8'h00;
      lo_drv = 8'h00;
    end
  end

  emp_pad_drv u_up_pad (
    .i_val        (up_val),
    .i_drive      (up_drv),
    .i_open_drain (cfg[CFG_OPEN_DRAIN]),
    .o_out        (O_UPPER_ADDR_PORT_PINS),
    .o_oe         (O_UPPER_ADDR_PORT_PINS_OE)
  );

  emp_pad_drv u_lo_pad (
    .i_val        (lo_val),
    .i_drive      (lo_drv),
    .i_open_drain (cfg[CFG_OPEN_DRAIN]),
    .o_out        (O_LOW_ADDR_DATA_PORT_PINS),
    .o_oe         (O_LOW_ADDR_DATA_PORT_PINS_OE)
  );

  assign O_ADDR_LATCH_STROBE_N  = !(state == EMP_ADDR);
  assign O_TRANSFER_STROBE_N    = !(state == EMP_DATA);
  assign O_READ_WRITE           = busy ? !xwrite : 1'b1;
  assign O_ADDR_LATCH_STROBE_OE = !cfg[CFG_FLOAT];
  assign O_TRANSFER_STROBE_OE   = !cfg[CFG_FLOAT];
  assign O_READ_WRITE_OE        = !cfg[CFG_FLOAT];
  assign O_LOW_EMI              = cfg[CFG_LOW_EMI];
  // Handshake strobes reflect port readiness; direction from upper nibble
  assign O_PORT3_LINE5 = cfg[CFG_UP_HS] &&
                         (cfg[CFG_UP_HI_MODE+:2] == MODE_OUT);
  assign O_PORT3_LINE4 = cfg[CFG_LO_HS] && I_PORT3_LINE3;
endmodule // emp_ext_mem_port
`default_nettype wire

// ===== tb/emp_ext_mem_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
module emp_ext_mem_port_sva (
  input wire logic       I_REF_CLK,
  input wire logic       I_RST,
  input wire logic       O_ADDR_LATCH_STROBE_N,
  input wire logic       O_ADDR_LATCH_STROBE_OE,
  input wire logic       O_TRANSFER_STROBE_N,
  input wire logic       O_TRANSFER_STROBE_OE,
  input wire logic       O_READ_WRITE,
  input wire logic       O_READ_WRITE_OE,
  input wire logic [7:0] O_UPPER_ADDR_PORT_PINS_OE,
  input wire logic [7:0] O_LOW_ADDR_DATA_PORT_PINS,
  input wire logic [7:0] O_LOW_ADDR_DATA_PORT_PINS_OE
);
  wire logic       latch = O_ADDR_LATCH_STROBE_N;
  wire logic       xstb  = O_TRANSFER_STROBE_N;
  wire logic       rw    = O_READ_WRITE;
  wire logic [7:0] lo    = O_LOW_ADDR_DATA_PORT_PINS;
  wire logic [7:0] loe   = O_LOW_ADDR_DATA_PORT_PINS_OE;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  property p_latch_pulse; $fell(latch) |=> latch [*4]; endproperty
  a_latch_pulse: assert property (p_latch_pulse) else $error("pulse");
  property p_latch_addr;
    !latch |-> loe == 8'hff ##1
      ($rose(latch) && loe == 8'hff && $stable(lo));
  endproperty
  a_latch_addr: assert property (p_latch_addr) else $error("addr lost");
  property p_latch_xstb; $fell(latch) |-> ##2 $fell(xstb); endproperty
  a_latch_xstb: assert property (p_latch_xstb) else $error("no xfer");
  property p_xstb_len; $fell(xstb) |=> !xstb ##[1:3] $rose(xstb); endproperty
  a_xstb_len: assert property (p_xstb_len) else $error("xfer width");
  property p_excl; latch || xstb; endproperty
  a_excl: assert property (p_excl) else $error("strobes overlap");
  property p_rw_hold; !xstb && !$past(xstb) |-> $stable(rw); endproperty
  a_rw_hold: assert property (p_rw_hold) else $error("rw moved");
  property p_wr_data;
    !xstb && !rw |-> loe == 8'hff && ($past(xstb) || $stable(lo));
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data");
  property p_rd_free; !xstb && rw |-> loe == 8'h00; endproperty
  a_rd_free: assert property (p_rd_free) else $error("bus held");
  property p_float;
    !O_ADDR_LATCH_STROBE_OE |-> !O_TRANSFER_STROBE_OE && !O_READ_WRITE_OE
      && O_UPPER_ADDR_PORT_PINS_OE == 8'h00 && loe == 8'h00;
  endproperty
  a_float: assert property (p_float) else $error("float partial");
endmodule // emp_ext_mem_port_sva
bind emp_ext_mem_port emp_ext_mem_port_sva i_sva (
  .I_REF_CLK(I_REF_CLK), .I_RST(I_RST),
  .O_ADDR_LATCH_STROBE_N(O_ADDR_LATCH_STROBE_N),
  .O_ADDR_LATCH_STROBE_OE(O_ADDR_LATCH_STROBE_OE),
  .O_TRANSFER_STROBE_N(O_TRANSFER_STROBE_N),
  .O_TRANSFER_STROBE_OE(O_TRANSFER_STROBE_OE),
  .O_READ_WRITE(O_READ_WRITE), .O_READ_WRITE_OE(O_READ_WRITE_OE),
  .O_UPPER_ADDR_PORT_PINS_OE(O_UPPER_ADDR_PORT_PINS_OE),
  .O_LOW_ADDR_DATA_PORT_PINS(O_LOW_ADDR_DATA_PORT_PINS),
  .O_LOW_ADDR_DATA_PORT_PINS_OE(O_LOW_ADDR_DATA_PORT_PINS_OE));
`default_nettype wire

// ===== tb/emp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module emp_mem_model (
  input  wire logic        clk,
  input  wire logic        latch_n,
  input  wire logic        xstb_n,
  input  wire logic        rw,
  input  wire logic [15:0] pins,
  output logic [7:0]       drv,
  output logic             vld,
  output logic [31:0]      res
);
  logic [7:0]  mem [0:65535];
  logic [15:0] a = 16'h0;
  logic [7:0]  d = 8'h0, last = 8'h0;
  logic [6:0]  w = 7'h0;
  logic        xstb_q = 1'b1, r = 1'b1;
  // Released bus toggles so a stale byte never passes for read data
  assign drv = (!xstb_n && rw) ? mem[a] : ~last;
  initial vld = 1'b0;
  always @(posedge clk) begin
    vld <= 1'b0;
    xstb_q <= xstb_n;
    last <= drv;
    if (!latch_n) a <= pins;
    if (!xstb_n) begin
      w <= w + 7'h1;
      d <= pins[7:0];
      r <= rw;
    end
    if (xstb_n && !xstb_q) begin
      vld <= 1'b1;
      res <= {r, w, a, d};
      if (!r) mem[a] = d;
      w <= 7'h0;
    end
  end
endmodule // emp_mem_model
`default_nettype wire

// ===== tb/emp_ext_mem_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module emp_ext_mem_port_bench;
  import emp_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, sel_n = 1'b0, l2 = 1'b0, l3 = 1'b0;
  logic        hwrite = 1'b0, latch_n, latch_oe, xstb_n, xstb_oe, rw, rw_oe;
  logic        l4, l5, emi, hrdy, hresp, vld;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, res, r;
  logic [7:0]  up_ext = 8'h0, up_o, up_oe, lo_o, lo_oe, drv, d;
  logic [7:0]  shadow [0:65535];
  logic [15:0] a;
  logic [31:0] expq [$];
  int          failures = 0, n_checks = 0;
  wire logic [7:0] up_bus = (up_oe & up_o) | (~up_oe & up_ext);
  wire logic [7:0] lo_bus = (lo_oe & lo_o) | (~lo_oe & drv);
  always #50 clk = ~clk;
  emp_ext_mem_port i_emp_ext_mem_port (
    .I_REF_CLK(clk), .I_RST(rst), .I_HSEL(1'b1), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
    .I_HWDATA(hwdata), .I_HREADY(hrdy), .O_HRDATA(hrdata),
    .O_HREADYOUT(hrdy), .O_HRESP(hresp), .I_EXT_ONLY_SELECT_N(sel_n),
    .O_ADDR_LATCH_STROBE_N(latch_n), .O_ADDR_LATCH_STROBE_OE(latch_oe),
    .O_TRANSFER_STROBE_N(xstb_n), .O_TRANSFER_STROBE_OE(xstb_oe),
    .O_READ_WRITE(rw), .O_READ_WRITE_OE(rw_oe),
    .I_UPPER_ADDR_PORT_PINS(up_bus), .O_UPPER_ADDR_PORT_PINS(up_o),
    .O_UPPER_ADDR_PORT_PINS_OE(up_oe), .I_LOW_ADDR_DATA_PORT_PINS(lo_bus),
    .O_LOW_ADDR_DATA_PORT_PINS(lo_o), .O_LOW_ADDR_DATA_PORT_PINS_OE(lo_oe),
    .I_PORT3_LINE2(l2), .I_PORT3_LINE3(l3), .O_PORT3_LINE4(l4),
    .O_PORT3_LINE5(l5), .O_LOW_EMI(emi));
  emp_mem_model i_emp_mem_model (.clk(clk), .latch_n(latch_n),
    .xstb_n(xstb_n),
    .rw(rw), .pins({up_bus, lo_bus}), .drv(drv), .vld(vld), .res(res));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task do_reset(input logic s);
    rst <= 1'b1;
    sel_n <= s;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task ahb_wr(input logic [31:0] ad, input logic [31:0] dt);
    htrans <= 2'h2; haddr <= ad; hwrite <= 1'b1;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    htrans <= 2'h0; hwdata <= dt;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
  endtask
  // Read data is taken at the edge that ends the data phase
  task ahb_rd(input logic [31:0] ad, output logic [31:0] dt);
    htrans <= 2'h2; haddr <= ad; hwrite <= 1'b0;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    dt = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task xfer(input logic wr, st, input logic [15:0] ad, pa,
            input logic [7:0] dd, input logic [6:0] w);
    int i;
    logic [7:0] e;
    e = wr ? dd : shadow[pa];
    if (wr) shadow[pa] = dd;
    expq.push_back({~wr, w, pa, e});
    ahb_wr(OFF_XFER, {dd, 6'h0, st, wr, ad});
    i = 0;
    r = 32'h1;
    while (r[0] !== 1'b0 && i < 40) begin
      ahb_rd(OFF_STATUS, r);
      i++;
    end
    chk("idle", 32'h0, {31'h0, r[0]});
  endtask
  always @(posedge clk) if (vld === 1'b1)
    chk("xfer", expq.size() ? expq.pop_front() : 32'hx, res);
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'h8533));
    do_reset(1'b0);
    ahb_rd(OFF_PORT_CFG, r); chk("cfg", {20'h0, CFG_RST_EXT}, r & 32'hfff);
    ahb_rd(OFF_STATUS, r); chk("ext", 32'h4, r & 32'h4);
    ahb_rd(OFF_STACK, r); chk("sp", 32'h0, r & 32'hffff);
    for (int k = 0; k < 4; k++) begin
      a = 16'($urandom);
      d = 8'($urandom);
      xfer(1'b1, 1'b0, a, a, d, 7'd4);
      xfer(1'b0, 1'b0, a, a, 8'h0, 7'd4);
      ahb_rd(OFF_RDATA, r); chk("rdata", {24'h0, d}, r & 32'hff);
    end
    ahb_wr(OFF_PORT_CFG, 32'h02a);
    xfer(1'b1, 1'b0, a, a, ~d, 7'd2);
    xfer(1'b0, 1'b0, a, a, 8'h0, 7'd2);
    ahb_wr(OFF_PORT_CFG, 32'h026);
    ahb_wr(OFF_UP_IO, 32'ha0);
    xfer(1'b1, 1'b0, a, {4'ha, a[11:0]}, d, 7'd2);
    ahb_wr(OFF_PORT_CFG, 32'h066);
    @(posedge clk); chk("hs5", 32'h1, {31'h0, l5});
    l3 <= 1'b1;
    l2 <= 1'($urandom);
    ahb_wr(OFF_PORT_CFG, 32'h2a0);
    @(posedge clk); chk("hs4", 32'h3, {30'h0, emi, l4});
    ahb_rd(OFF_STATUS, r); chk("lines", {26'h0, l3, l2, 4'h0}, r & 32'h30);
    ahb_wr(OFF_PORT_CFG, 32'h02a);
    ahb_wr(OFF_STACK, 32'hbeef);
    ahb_rd(OFF_STACK, r); chk("sp", 32'hbeef, r & 32'hffff);
    xfer(1'b1, 1'b1, a, a, d, 7'd2);
    ahb_rd(OFF_STACK, r); chk("sp", 32'h0, r & 32'hffff);
    ahb_wr(OFF_PORT_CFG, 32'h82a);
    @(posedge clk);
    chk("float", 32'h0, {13'h0, latch_oe, xstb_oe, rw_oe, up_oe, lo_oe});
    ahb_wr(32'h20, 32'h5);
    ahb_rd(32'h20, r); chk("unmapped", 32'h0, r);
    do_reset(1'b1);
    ahb_rd(OFF_PORT_CFG, r); chk("cfg", {20'h0, CFG_RST_INT}, r & 32'hfff);
    up_ext <= 8'($urandom);
    repeat (3) @(posedge clk);
    ahb_rd(OFF_UP_IO, r); chk("upin", {24'h0, up_ext}, {16'h0, up_oe, r[7:0]});
    repeat (10) @(posedge clk);
    chk("pending", 32'h0, 32'(expq.size()));
    tally_and_finish;
  end
endmodule // emp_ext_mem_port_bench
`default_nettype wire
